// [design/bdr_seq.sv]
// Supply-dip reset sequencer: turns a supply-monitor trip into a device
// reset pulse, steers clock start-up and releases the internal reset.
// Assumes asynchronous comparator and oscillator status inputs, a single
// 100 MHz always-on clock and a one-cycle-strobe register port.
//
// Contract
// - A detected supply dip produces a reset pulse for the whole device.
// - After the dip, clock source follows select and oscillator mode fields.
// - Oscillator modes start the start-up timer; clock gated until expiry.
// - With PLL in use, clock held until lock bit 5 reads one.
// - Power-up delay runs alongside clock start; reset released after it.
// - Zero power-up delay with crystal uses the clock-monitor delay instead.
// - Every supply-dip reset sets cause flag bit 1 for software.
// - Detection stays active in Sleep and Idle, resetting in either mode.
// - Sleep stops CPU and peripheral clocks, Idle halts CPU only; detection works in both.
`timescale 1ns/1ns
module bdr_seq
    import bdr_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        reset_in,
    input  wire logic        supply_dip_in,
    input  wire logic        osc_startup_done_in,
    input  wire logic        pll_lock_in,
    input  wire logic        sleep_mode_in,
    input  wire logic        idle_mode_in,
    input  wire bdr_req_s    reg_req_in,
    output logic [15:0]      reg_rdata_out,
    output logic             dev_reset_pulse_out,
    output logic             int_reset_out,
    output logic             sys_clk_en_out,
    output logic             cpu_clk_en_out,
    output logic             periph_clk_en_out,
    output logic             osc_startup_timer_start_out,
    output logic [2:0]       clk_source_out,
    output logic             pll_en_out,
    output logic             irq_out
);

    // Two-stage synchronisers for asynchronous inputs
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {pll_lock_in, osc_startup_done_in, supply_dip_in};
            sync2_q <= sync1_q;
        end
    end

    bdr_osc_s osc;
    wire      dip_s = sync2_q[0];
    assign osc.ost_done = sync2_q[1];
    assign osc.pll_lock = sync2_q[2];

    // Rising edge of the monitor trip, seen in every power mode
    logic dip_d1_q;
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            dip_d1_q <= 1'b0;
        end else begin
            dip_d1_q <= dip_s;
        end
    end
    wire dip_event = dip_s & ~dip_d1_q;

    // Register decode
    logic [15:0] cfg_q;
    logic [15:0] cause_q;
    logic [1:0]  irq_st_q;
    logic [1:0]  irq_en_q;
    wire wr_cause  = reg_req_in.wr && reg_req_in.addr == ADDR_CAUSE;
    wire wr_cfg    = reg_req_in.wr && reg_req_in.addr == ADDR_CFG;
    wire wr_irq_en = reg_req_in.wr && reg_req_in.addr == ADDR_IRQ_EN;
    wire wr_irq_cl = reg_req_in.wr && reg_req_in.addr == ADDR_IRQ_CL;

    // Configuration fields
    wire [2:0] sel_f  = cfg_q[CFG_SEL_LSB +: 3];
    wire [1:0] mode_f = cfg_q[CFG_MODE_LSB +: 2];
    wire       pud_f  = cfg_q[CFG_PUD_BIT];

    // Clock source decisions taken from the latched configuration
    wire use_pri  = (sel_f == SEL_PRI) || (sel_f == SEL_PRI_PLL);
    wire use_pll  = (sel_f == SEL_FRC_PLL) || (sel_f == SEL_PRI_PLL);
    wire osc_mode = use_pri && (mode_f != MODE_OFF);
    wire crystal  = use_pri && (mode_f == MODE_XT || mode_f == MODE_HS);

    // Sequencer state and counters
    bdr_state_e      state_q, state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] delay_q;
    logic            clk_ok_q;
    logic            delay_ok_q;

    wire clk_ready = (!osc_mode || osc.ost_done)
                   && (!use_pll || osc.pll_lock);
    wire cnt_done  = cnt_q == '0;

    // Release delay: power-up delay, or clock-monitor delay for crystals
    wire [CNT_W-1:0] rel_delay =
        pud_f   ? CNT_W'(PUD_CYC) :
        crystal ? CNT_W'(CMON_CYC) : CNT_W'(1);

    // Next-state logic
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN:   if (dip_event) state_d = ST_PULSE;
            ST_PULSE: if (cnt_done) state_d = ST_WAIT;
            ST_WAIT:  if (dip_event) state_d = ST_PULSE;
                      else if (clk_ok_q && delay_ok_q) state_d = ST_RUN;
            ST_IDLE:  state_d = ST_RUN;
            default:  state_d = ST_RUN;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Pulse width counter runs in the pulse state; release delay counter counts down after it, in the wait state
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            cnt_q   <= '0;
            delay_q <= '0;
        end else if (state_d == ST_PULSE && state_q != ST_PULSE) begin
            cnt_q   <= CNT_W'(RST_PULSE_CYC - 1);
            delay_q <= rel_delay;
        end else begin
            if (!cnt_done) begin
                cnt_q <= cnt_q - 1'b1;
            end
            if (state_q == ST_WAIT && delay_q != '0) begin
                delay_q <= delay_q - 1'b1;
            end
        end
    end

    // Completion flags for clock start-up and the release delay
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            clk_ok_q   <= 1'b0;
            delay_ok_q <= 1'b0;
        end else if (state_q != ST_WAIT) begin
            clk_ok_q   <= 1'b0;
            delay_ok_q <= 1'b0;
        end else begin
            clk_ok_q   <= clk_ready;
            delay_ok_q <= delay_q <= CNT_W'(1);
        end
    end

    // Configuration register, steers source selection and delays
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            cfg_q <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg_q <= reg_req_in.wdata;
        end
    end

    // Cause flag: set by hardware wins over a software clear
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            cause_q <= CAUSE_RESET;
        end else if (dip_event) begin
            cause_q[CAUSE_DIP_BIT] <= 1'b1;
        end else if (wr_cause && !reg_req_in.wdata[CAUSE_DIP_BIT]) begin
            cause_q[CAUSE_DIP_BIT] <= 1'b0;
        end
    end

    // Interrupt status: dip seen and reset released; set wins over clear
    wire [1:0] irq_set;
    assign irq_set[IRQ_DIP_BIT] = dip_event;
    assign irq_set[IRQ_REL_BIT] = state_q == ST_WAIT && state_d == ST_RUN;
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            irq_st_q <= 2'h0;
            irq_en_q <= IRQ_EN_RST;
        end else begin
            irq_st_q <= irq_set
                      | (irq_st_q & ~(wr_irq_cl ? reg_req_in.wdata[1:0]
                                                 : 2'h0));
            if (wr_irq_en) begin
                irq_en_q <= reg_req_in.wdata[1:0];
            end
        end
    end
    assign irq_out = |(irq_st_q & irq_en_q);

    // Read data, valid the cycle after the strobe
    wire [15:0] osc_view = 16'(osc.pll_lock) << OSC_LOCK_BIT;
    logic [15:0] rd_mux;
    always_comb begin
        case (reg_req_in.addr)
            ADDR_CAUSE:  rd_mux = cause_q;
            ADDR_OSCCTL: rd_mux = osc_view | 16'(sel_f);
            ADDR_CFG:    rd_mux = cfg_q;
            ADDR_IRQ_ST: rd_mux = {14'h0, irq_st_q};
            ADDR_IRQ_EN: rd_mux = {14'h0, irq_en_q};
            default:     rd_mux = 16'h0000;
        endcase
    end
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_req_in.rd) begin
            reg_rdata_out <= rd_mux;
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

    // Outputs toward the device
    wire in_seq = state_q != ST_RUN;
    assign dev_reset_pulse_out = state_q == ST_PULSE;
    assign int_reset_out       = in_seq;
    assign osc_startup_timer_start_out = state_q == ST_WAIT && osc_mode;
    assign sys_clk_en_out      = !in_seq;
    assign cpu_clk_en_out      = !in_seq && !sleep_mode_in
                               && !idle_mode_in;
    assign periph_clk_en_out   = !in_seq && !sleep_mode_in;
    assign clk_source_out      = sel_f;
    assign pll_en_out          = use_pll;

endmodule

// [inc/bdr_pkg.sv]
// Package for the supply-dip reset sequencer: register map, field layout,
// timing constants and the carrier structs.
// Assumes a 100 MHz system clock and a plain strobe register port.
package bdr_pkg;

    // Clock rate
    localparam int unsigned CLK_HZ = 100_000_000;

    // Register word offsets
    localparam logic [3:0] ADDR_CAUSE  = 4'h0;
    localparam logic [3:0] ADDR_OSCCTL = 4'h1;
    localparam logic [3:0] ADDR_CFG    = 4'h2;
    localparam logic [3:0] ADDR_IRQ_ST = 4'h3;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h4;
    localparam logic [3:0] ADDR_IRQ_CL = 4'h5;

    // Field positions
    localparam int unsigned CAUSE_DIP_BIT = 1;
    localparam int unsigned OSC_LOCK_BIT  = 5;
    localparam int unsigned CFG_SEL_LSB   = 0;
    localparam int unsigned CFG_MODE_LSB  = 3;
    localparam int unsigned CFG_PUD_BIT   = 5;
    localparam int unsigned IRQ_DIP_BIT   = 0;
    localparam int unsigned IRQ_REL_BIT   = 1;

    // Reset values
    localparam logic [15:0] CFG_RESET   = 16'h0000;
    localparam logic [1:0]  IRQ_EN_RST  = 2'h0;
    localparam logic [15:0] CAUSE_RESET = 16'h0000;

    // Clock source select codes
    localparam logic [2:0] SEL_FRC     = 3'h0;
    localparam logic [2:0] SEL_FRC_PLL = 3'h1;
    localparam logic [2:0] SEL_PRI     = 3'h2;
    localparam logic [2:0] SEL_PRI_PLL = 3'h3;
    // Primary oscillator modes
    localparam logic [1:0] MODE_EC     = 2'h0;
    localparam logic [1:0] MODE_XT     = 2'h1;
    localparam logic [1:0] MODE_HS     = 2'h2;
    localparam logic [1:0] MODE_OFF    = 2'h3;

    // Timing: reset pulse and delays as times with derived counts, start-up timer in cycles
    localparam int unsigned RST_PULSE_NS  = 100;
    localparam int unsigned OST_CYCLES    = 1024;
    localparam int unsigned PUD_US        = 64;
    localparam int unsigned CMON_US       = 500;
    localparam int unsigned RST_PULSE_CYC =
        (RST_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned PUD_CYC  = PUD_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CMON_CYC = CMON_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CNT_W = 24;

    // Sequencer states
    typedef enum logic [3:0] {
        ST_RUN   = 4'b0001,
        ST_PULSE = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_IDLE  = 4'b1000
    } bdr_state_e;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } bdr_req_s;

    // Oscillator status from the analog side
    typedef struct packed {
        logic ost_done;
        logic pll_lock;
    } bdr_osc_s;

endpackage

// [test/bdr_seq_asserts.sv]
// Checker on the ports of the supply-dip reset sequencer.
// Assumes bdr_pkg is compiled first and one clock domain.
`timescale 1ns/1ns
module bdr_seq_asserts
    import bdr_pkg::*;
(
    input wire logic       clk_sys_in,
    input wire logic       reset_in,
    input wire logic       supply_dip_in,
    input wire logic       osc_startup_done_in,
    input wire logic       pll_lock_in,
    input wire logic       sleep_mode_in,
    input wire logic       idle_mode_in,
    input wire bdr_req_s   reg_req_in,
    input wire logic       dev_reset_pulse_out,
    input wire logic       int_reset_out,
    input wire logic       sys_clk_en_out,
    input wire logic       cpu_clk_en_out,
    input wire logic       osc_startup_timer_start_out,
    input wire logic [2:0] clk_source_out,
    input wire logic       pll_en_out,
    input wire logic       irq_out
);
    logic [15:0] cfg_q;
    logic [1:0]  en_q;
    logic [16:0] held_q;
    wire         cfg_wr = reg_req_in.wr && reg_req_in.addr == ADDR_CFG;
    wire         en_wr  = reg_req_in.wr && reg_req_in.addr == ADDR_IRQ_EN;
    wire         xtal   = cfg_q[2:1] == 2'h1
                        && (cfg_q[4:3] == MODE_XT || cfg_q[4:3] == MODE_HS);
    // Shadow config and enable; count cycles of internal reset
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            cfg_q  <= CFG_RESET;
            en_q   <= IRQ_EN_RST;
            held_q <= 17'h00000;
        end else begin
            cfg_q  <= cfg_wr ? reg_req_in.wdata : cfg_q;
            en_q   <= en_wr ? reg_req_in.wdata[1:0] : en_q;
            held_q <= int_reset_out ? held_q + 17'h00001 : 17'h00000;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    pulse_len_a: assert property (
        $rose(dev_reset_pulse_out) |-> dev_reset_pulse_out[*8] ##1
        dev_reset_pulse_out ##1 dev_reset_pulse_out ##1 !dev_reset_pulse_out
    ) else $error("reset pulse length wrong");
    dip_trip_a: assert property (
        $rose(supply_dip_in) && !int_reset_out
        |-> ##[2:6] $rose(dev_reset_pulse_out)) else $error("dip missed");
    clk_gate_a: assert property (
        sys_clk_en_out == !int_reset_out) else $error("clock gate wrong");
    ost_hold_a: assert property (
        int_reset_out && osc_startup_timer_start_out && !osc_startup_done_in
        |=> int_reset_out) else $error("released before start-up");
    pll_hold_a: assert property (
        int_reset_out && pll_en_out && !pll_lock_in |=> int_reset_out)
        else $error("released before lock");
    pud_wait_a: assert property (
        $fell(int_reset_out) && cfg_q[CFG_PUD_BIT] |-> held_q >= PUD_CYC)
        else $error("power-up delay short");
    cmon_wait_a: assert property (
        $fell(int_reset_out) && !cfg_q[CFG_PUD_BIT] && xtal
        |-> held_q >= CMON_CYC) else $error("monitor delay short");
    clk_src_a: assert property (
        clk_source_out == cfg_q[2:0] && pll_en_out == (cfg_q[2:0] ==
        SEL_FRC_PLL || cfg_q[2:0] == SEL_PRI_PLL)) else $error("bad source");
    irq_flag_a: assert property (
        $rose(dev_reset_pulse_out) && en_q[IRQ_DIP_BIT] |-> irq_out)
        else $error("dip interrupt missing");
    mode_gate_a: assert property (
        cpu_clk_en_out == (sys_clk_en_out && !sleep_mode_in && !idle_mode_in))
        else $error("cpu clock gate wrong");
endmodule
bind bdr_seq bdr_seq_asserts i_chk (.*);

// [test/bdr_osc_model.sv]
// Model of the supply comparator and oscillator start-up circuits.
// Assumes the sequencer's internal reset marks the start-up period.
`timescale 1ns/1ns
module bdr_osc_model
    import bdr_pkg::*;
#(
    parameter int LOCK_CYC = 300
)(
    input  wire logic clk_in,
    input  wire logic hold_in,
    input  wire logic dip_req_in,
    input  wire logic ost_start_in,
    input  wire logic pll_en_in,
    output logic      supply_dip_out,
    output logic      ost_done_out,
    output logic      pll_lock_out
);
    int n;
    bit hold_q;
    // Start-up time restarts as the device enters reset; lock then stays
    // while the loop is enabled, so the lock bit can be read after release
    always @(posedge clk_in) begin
        hold_q <= hold_in;
        n <= (hold_in && !hold_q) ? 0 : n + 1;
    end
    assign supply_dip_out = dip_req_in;
    assign ost_done_out   = ost_start_in && n >= OST_CYCLES;
    assign pll_lock_out   = pll_en_in && n >= LOCK_CYC;
endmodule

// [test/bdr_seq_tb.sv]
// Self-checking bench for the supply-dip reset sequencer.
// Assumes the package, design, model and checker are compiled first.
`timescale 1ns/1ns
module bdr_seq_tb;
    import bdr_pkg::*;
    logic clk_sys_in, reset_in, sleep_mode_in, idle_mode_in, dip_req;
    bdr_req_s reg_req_in;
    wire logic supply_dip_in, osc_startup_done_in, pll_lock_in, pll_en_out;
    wire logic [15:0] reg_rdata_out;
    wire logic [2:0] clk_source_out;
    wire logic dev_reset_pulse_out, int_reset_out, sys_clk_en_out, irq_out;
    wire logic cpu_clk_en_out, periph_clk_en_out, osc_startup_timer_start_out;
    int fail_count, comparisons, cycles, n, d;
    logic [31:0] rnd;
    logic [15:0] cfg;
    bdr_seq i_dut (.*);
    bdr_osc_model i_osc (.clk_in(clk_sys_in), .hold_in(int_reset_out),
        .dip_req_in(dip_req), .ost_start_in(osc_startup_timer_start_out),
        .pll_en_in(pll_en_out), .supply_dip_out(supply_dip_in),
        .ost_done_out(osc_startup_done_in), .pll_lock_out(pll_lock_in));
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // Cut a hang short
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            fail_count++;
            end_of_test();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [15:0] gate_exp(input logic sl, input logic id);
        return {14'h0000, !sl && !id, !sl};
    endfunction
    // Hold length within a small margin of the expected delay
    function automatic logic [15:0] near(input int got, input int want);
        return {15'h0000, got >= want - 32 && got <= want + 32};
    endfunction
    // Oscillator control view: lock bit for loop sources, then select
    function automatic logic [15:0] osc_exp(input logic [15:0] c);
        logic pll;
        pll = c[2:0] == SEL_FRC_PLL || c[2:0] == SEL_PRI_PLL;
        return {10'h000, pll, 2'h0, c[2:0]};
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_req_in <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys_in);
        reg_req_in <= '0;
        @(posedge clk_sys_in);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] m, e);
        reg_req_in <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk_sys_in);
        reg_req_in <= '0;
        #1 check(reg_rdata_out & m, e);
        @(posedge clk_sys_in);
    endtask
    task automatic trip();
        dip_req <= 1'b1;
        repeat (20) @(posedge clk_sys_in);
        dip_req <= 1'b0;
        n = 0;
        while (int_reset_out !== 1'b0 && n < 60000) begin
            @(posedge clk_sys_in);
            n++;
        end
        @(posedge clk_sys_in);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        reset_in = 1'b1;
        sleep_mode_in = 1'b0;
        idle_mode_in = 1'b0;
        dip_req = 1'b0;
        reg_req_in = '0;
        rnd = 32'h0000002A;
        repeat (3) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        @(posedge clk_sys_in);
        rd(ADDR_CFG, 16'hFFFF, CFG_RESET);
        rd(ADDR_CAUSE, 16'hFFFF, CAUSE_RESET);
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'hFFFF, 16'h0000);
        // Every select code with power-up delay, then crystal with none
        for (int k = 0; k < 5; k++) begin
            rnd = xs(rnd);
            cfg = k < 4 ? {10'h000, 1'b1, rnd[1:0], 3'(k)} : 16'h000A;
            sleep_mode_in <= k == 3;
            idle_mode_in <= k == 2;
            wr(ADDR_CFG, cfg);
            wr(ADDR_IRQ_EN, {14'h0000, rnd[3:2]});
            check({13'h0000, clk_source_out}, {13'h0000, cfg[2:0]});
            trip();
            d = k < 4 ? PUD_CYC : CMON_CYC;
            check(near(n, d), 16'h0001);
            rd(ADDR_CAUSE, 16'h0002, 16'h0002);
            rd(ADDR_IRQ_ST, 16'h0003, 16'h0003);
            rd(ADDR_OSCCTL, 16'hFFFF, osc_exp(cfg));
            check({15'h0000, irq_out}, {15'h0000, |rnd[3:2]});
            check({14'h0000, cpu_clk_en_out, periph_clk_en_out},
                gate_exp(k == 3, k == 2));
            wr(ADDR_CAUSE, 16'h0000);
            rd(ADDR_CAUSE, 16'h0002, 16'h0000);
            wr(ADDR_IRQ_CL, 16'h0003);
            rd(ADDR_IRQ_ST, 16'h0003, 16'h0000);
            $display("test %0d done", k);
        end
        // Power-on reset in mid-sequence drops the hold and the cause flag
        dip_req <= 1'b1;
        repeat (20) @(posedge clk_sys_in);
        rd(ADDR_CAUSE, 16'h0002, 16'h0002);
        check({15'h0000, int_reset_out}, 16'h0001);
        dip_req <= 1'b0;
        reset_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        @(posedge clk_sys_in);
        check({15'h0000, int_reset_out}, 16'h0000);
        rd(ADDR_CAUSE, 16'hFFFF, CAUSE_RESET);
        rd(ADDR_IRQ_EN, 16'hFFFF, {14'h0000, IRQ_EN_RST});
        $display("test 5 done");
        end_of_test();
    end
endmodule
